// ### verilog/ccsb_pkg.sv
// Purpose: Shared constants and types for the completion sideband check.
// Assumes: One user clock, 256-bit data path by default.
// Notes: Sideband bit 0 is the abort flag, bits 32:1 the byte parity.
package ccsb_pkg;
  localparam int CCSB_DATA_W = 256;
  localparam int CCSB_BYTES = CCSB_DATA_W / 8;
  localparam int CCSB_SB_W = 33;
  localparam int CCSB_ABORT_BIT = 0;
  localparam int CCSB_PAR_LSB = 1;
  localparam int CCSB_PAR_W = 32;
  localparam int CCSB_PAR_USED_256 = 32;
  localparam int CCSB_PAR_USED_128 = 16;
  localparam int CCSB_PAR_USED_64 = 8;
  localparam logic [1:0] CCSB_WIDTH_64 = 2'h0;
  localparam logic [1:0] CCSB_WIDTH_128 = 2'h1;
  localparam logic [1:0] CCSB_WIDTH_256 = 2'h2;
  localparam logic [31:0] CCSB_MASK_64 = 32'h0000_00ff;
  localparam logic [31:0] CCSB_MASK_128 = 32'h0000_ffff;
  localparam logic [31:0] CCSB_MASK_256 = 32'hffff_ffff;

  typedef enum logic [1:0] {
    CCSB_RX_IDLE = 2'h0,
    CCSB_RX_BODY = 2'h1,
    CCSB_RX_ABORT = 2'h3,
    CCSB_RX_DROP = 2'h2
  } ccsb_rx_e;

  typedef enum logic [1:0] {
    CCSB_TX_IDLE = 2'h0,
    CCSB_TX_SEND = 2'h1,
    CCSB_TX_HOLD = 2'h3
  } ccsb_tx_e;

  // Odd parity of every byte: each bit makes its byte plus itself odd.
  function automatic logic [CCSB_PAR_W-1:0] ccsb_odd_parity(input logic [CCSB_DATA_W-1:0] d);
    logic [CCSB_PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < CCSB_BYTES; i++) begin
      p[i] = ~(^d[i*8 +: 8]);
    end
    return p;
  endfunction : ccsb_odd_parity

  // Mask of meaningful parity bits for the configured data path width.
  function automatic logic [CCSB_PAR_W-1:0] ccsb_par_mask(input logic [1:0] w);
    logic [CCSB_PAR_W-1:0] m;
    m = CCSB_MASK_256;
    if (w == CCSB_WIDTH_64) begin
      m = CCSB_MASK_64;
    end else if (w == CCSB_WIDTH_128) begin
      m = CCSB_MASK_128;
    end
    return m;
  endfunction : ccsb_par_mask
endpackage : ccsb_pkg

// ### verilog/ccsb_if.sv
// Purpose: Completion stream between user source and core sink.
// Assumes: Both ends on i_ref_clk.
// Notes: A beat moves when valid and ready are both high.
`timescale 1ns/1ns
interface ccsb_if;
  import ccsb_pkg::*;
  logic [CCSB_DATA_W-1:0] completion_data_bus;
  logic [CCSB_SB_W-1:0] completion_sideband_bus;
  logic completion_valid;
  logic completion_ready;
  logic completion_last_beat;

  modport source (
    output completion_data_bus, completion_sideband_bus, completion_valid,
    output completion_last_beat,
    input completion_ready
  );
  modport sink (
    input completion_data_bus, completion_sideband_bus, completion_valid,
    input completion_last_beat,
    output completion_ready
  );
endinterface : ccsb_if

// ### verilog/ccsb_parity_chk.sv
// Purpose: Compares the received parity field with the data bytes.
// Assumes: Data and parity come from the same beat.
// Notes: Purely combinational; unused parity lanes are masked off.
`timescale 1ns/1ns
module ccsb_parity_chk
  import ccsb_pkg::*;
(
  input wire logic [CCSB_DATA_W-1:0] i_data,
  input wire logic [CCSB_PAR_W-1:0] i_parity,
  input wire logic [1:0] i_width,
  input wire logic i_enable,
  output logic o_error
);
  // Only the low lanes for the width count; disabled checking never errs.
  wire [CCSB_PAR_W-1:0] lane_mask = ccsb_par_mask(i_width);
  wire [CCSB_PAR_W-1:0] lane_diff = (ccsb_odd_parity(i_data) ^ i_parity) & lane_mask;
  assign o_error = i_enable & (|lane_diff);
endmodule : ccsb_parity_chk

// ### verilog/ccsb_core_sink.sv
// Purpose: Core end of the completion stream: abort and parity handling.
// Assumes: User source keeps the stream handshake rules.
// Assumes: Width, parity enable and endpoint mode are static while packets flow.
// Assumes: Downstream takes the registered copy whenever it pulses.
// Notes: Accepted beats go out as a registered copy with a packet verdict.
// Notes: Verdict pulses follow the packet's last beat by one cycle.
// Notes: After a parity error the broken packet drains, then ready stays low.
// Notes: An abort flag in the first beat of a packet is ignored.
`timescale 1ns/1ns
module ccsb_core_sink
  import ccsb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  ccsb_if.sink link,
  input wire logic [1:0] i_width,
  input wire logic i_parity_en,
  input wire logic i_is_endpoint,
  input wire logic i_out_ready,
  output logic [CCSB_DATA_W-1:0] o_data,
  output logic o_data_valid,
  output logic o_data_last,
  output logic o_nullify,
  output logic o_discard,
  output logic o_aer_report,
  output logic o_internal_err
);
  // Packet state and the sticky internal error.
  ccsb_rx_e state;
  ccsb_rx_e next_state;
  logic internal_err;
  logic par_err;

  // Byte parity of the data bus against the sideband parity field.
  ccsb_parity_chk u_par (
    .i_data(link.completion_data_bus),
    .i_parity(link.completion_sideband_bus[CCSB_PAR_LSB +: CCSB_PAR_W]),
    .i_width(i_width),
    .i_enable(i_parity_en),
    .o_error(par_err)
  );

  // Ready stalls when downstream is busy. After a parity error the broken
  // packet may still drain so that its discard verdict can appear; then
  // ready stays low until reset.
  wire draining = (state == CCSB_RX_DROP);
  wire blocked = internal_err & ~draining;
  assign link.completion_ready = i_out_ready & ~blocked;
  wire beat = link.completion_valid & link.completion_ready;
  wire abort_seen = beat & link.completion_sideband_bus[CCSB_ABORT_BIT];
  wire last = beat & link.completion_last_beat;
  wire first_beat = (state == CCSB_RX_IDLE);
  // Abort counts from the second beat onward; a first-beat flag is ignored.
  wire abort_now = abort_seen & ~first_beat;

  // Packet verdict so far, including the beat now on the bus.
  wire parity_bad = beat & par_err;
  wire aborted = (state == CCSB_RX_ABORT) | abort_now;
  wire dropped = (state == CCSB_RX_DROP) | parity_bad;

  // Packet state: body, sticky abort, or parity drop until last beat.
  always_comb begin
    next_state = state;
    case (state)
      CCSB_RX_IDLE: begin
        // A first beat opens a packet unless it is its only beat.
        if (beat & ~last) begin
          if (parity_bad) begin
            next_state = CCSB_RX_DROP;
          end else begin
            next_state = CCSB_RX_BODY;
          end
        end
      end
      CCSB_RX_BODY: begin
        // A parity error outranks an abort seen in the same beat.
        if (last) begin
          next_state = CCSB_RX_IDLE;
        end else if (parity_bad) begin
          next_state = CCSB_RX_DROP;
        end else if (abort_now) begin
          next_state = CCSB_RX_ABORT;
        end
      end
      CCSB_RX_ABORT: begin
        // The abort holds even if the flag drops before the last beat.
        if (last) begin
          next_state = CCSB_RX_IDLE;
        end else if (parity_bad) begin
          next_state = CCSB_RX_DROP;
        end
      end
      CCSB_RX_DROP: begin
        // Remaining beats are swallowed; the verdict comes at the last one.
        if (last) begin
          next_state = CCSB_RX_IDLE;
        end
      end
      default: begin
        // Any other value, such as X, falls back to waiting for a packet.
        next_state = CCSB_RX_IDLE;
      end
    endcase
  end

  // Holds the packet state.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state <= CCSB_RX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Error flag is sticky until reset; reset is the only recovery.
  wire next_internal_err = internal_err | parity_bad;

  // Holds the internal error flag.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      internal_err <= 1'b0;
    end else begin
      internal_err <= next_internal_err;
    end
  end

  // Next values of the registered outputs; verdicts close at the last beat.
  wire [CCSB_DATA_W-1:0] next_data = beat ? link.completion_data_bus : o_data;
  wire next_data_valid = beat & ~dropped;
  wire next_data_last = last & ~dropped;
  wire next_nullify = last & aborted & ~dropped;
  wire next_discard = last & dropped;
  wire next_aer_report = next_nullify & i_is_endpoint;

  // Holds the data of the newest accepted beat.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_data <= '0;
    end else begin
      o_data <= next_data;
    end
  end

  // Pulses once for each beat that is passed on.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_data_valid <= 1'b0;
    end else begin
      o_data_valid <= next_data_valid;
    end
  end

  // Marks the last beat of a packet that is passed on.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_data_last <= 1'b0;
    end else begin
      o_data_last <= next_data_last;
    end
  end

  // Nullify pulse for an aborted packet.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_nullify <= 1'b0;
    end else begin
      o_nullify <= next_nullify;
    end
  end

  // Discard pulse for a packet with a parity error.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_discard <= 1'b0;
    end else begin
      o_discard <= next_discard;
    end
  end

  // Error report of an aborted packet in endpoint mode.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_aer_report <= 1'b0;
    end else begin
      o_aer_report <= next_aer_report;
    end
  end

  // The sticky error flag goes out as it is.
  assign o_internal_err = internal_err;
endmodule : ccsb_core_sink

// ### verilog/ccsb_user_source.sv
// Purpose: User end of the completion stream, sending one packet per request.
// Assumes: Packet length of at least one beat; data from an incrementing seed.
// Notes: Aborts only on posted-class packets and never in the first beat.
`timescale 1ns/1ns
module ccsb_user_source
  import ccsb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  ccsb_if.source link,
  input wire logic i_start,
  input wire logic [7:0] i_beats,
  input wire logic [CCSB_DATA_W-1:0] i_seed,
  input wire logic i_non_posted,
  input wire logic i_abort_req,
  input wire logic i_end_on_abort,
  input wire logic i_parity_en,
  input wire logic [1:0] i_width,
  output logic o_busy
);
  ccsb_tx_e state;
  logic [7:0] left;
  logic [CCSB_DATA_W-1:0] data;
  logic abort_flag;
  logic np;
  logic first;

  wire beat = link.completion_valid & link.completion_ready;
  wire is_last = (left == 8'h01);
  // Abort allowed from the third beat on and not for non-posted packets.
  wire may_abort = i_abort_req & ~first & ~np;
  wire cut_short = abort_flag & i_end_on_abort;
  wire [CCSB_PAR_W-1:0] par = i_parity_en ? (ccsb_odd_parity(data) & ccsb_par_mask(i_width))
                                          : '0;

  assign link.completion_valid = (state != CCSB_TX_IDLE);
  assign link.completion_data_bus = data;
  assign link.completion_last_beat = (state != CCSB_TX_IDLE) & (is_last | cut_short);
  assign link.completion_sideband_bus = {par, abort_flag & link.completion_valid};
  assign o_busy = (state != CCSB_TX_IDLE);

  // Sequencer; data and flag hold while ready is low.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state <= CCSB_TX_IDLE;
      left <= 8'h00;
      data <= '0;
      abort_flag <= 1'b0;
      np <= 1'b0;
      first <= 1'b0;
    end else begin
      case (state)
        CCSB_TX_IDLE: begin
          if (i_start && i_beats != 8'h00) begin
            state <= CCSB_TX_SEND;
            left <= i_beats;
            data <= i_seed;
            np <= i_non_posted;
            first <= 1'b1;
            abort_flag <= 1'b0;
          end
        end
        CCSB_TX_SEND, CCSB_TX_HOLD: begin
          if (beat) begin
            first <= 1'b0;
            if (link.completion_last_beat) begin
              state <= CCSB_TX_IDLE;
              abort_flag <= 1'b0;
            end else begin
              state <= CCSB_TX_SEND;
              left <= left - 8'h01;
              data <= data + CCSB_DATA_W'(1);
              // The flag follows the request at each accepted beat.
              abort_flag <= may_abort;
            end
          end else begin
            state <= CCSB_TX_HOLD;
          end
        end
        default: begin
          state <= CCSB_TX_IDLE;
        end
      endcase
    end
  end
endmodule : ccsb_user_source

// ### testbench/ccsb_assertions.sv
// Purpose: Wire checks on the completion stream between the two ends.
// Assumes: One clock; synchronous active-low reset.
// Notes: Sees only the interface signals.
`timescale 1ns/1ns
module ccsb_assertions
  import ccsb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [CCSB_DATA_W-1:0] completion_data_bus,
  input wire logic [CCSB_SB_W-1:0] completion_sideband_bus,
  input wire logic completion_valid,
  input wire logic completion_ready,
  input wire logic completion_last_beat
);
  logic mid;
  wire logic xfer = completion_valid && completion_ready;
  wire logic ab = completion_sideband_bus[CCSB_ABORT_BIT];
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Tracks whether the next beat is inside a packet rather than its first.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mid <= 1'b0;
    end else if (xfer) begin
      mid <= !completion_last_beat;
    end
  end
  AST_ABORT_VALID: assert property (ab |-> completion_valid)
    else $error("abort flag without valid");
  AST_ABORT_FIRST: assert property (completion_valid && ab |-> mid)
    else $error("abort flag in first beat");
  AST_ABORT_HOLD: assert property (completion_valid && ab && !completion_ready |=> ab)
    else $error("abort flag dropped before ready");
  AST_VALID_HOLD: assert property (completion_valid && !completion_ready |=> completion_valid)
    else $error("valid dropped while stalled");
  AST_DATA_STABLE: assert property (completion_valid && !completion_ready |=>
    $stable(completion_data_bus))
    else $error("data changed while stalled");
  AST_SB_STABLE: assert property (completion_valid && !completion_ready |=>
    $stable(completion_sideband_bus) && $stable(completion_last_beat))
    else $error("sideband or last changed while stalled");
  AST_GAP: assert property (xfer && completion_last_beat |=> !completion_valid)
    else $error("no idle cycle after last beat");
  AST_END_ON_LAST: assert property ($fell(completion_valid) |->
    $past(xfer && completion_last_beat))
    else $error("valid fell without a last beat");
  COV_ABORT: cover property (xfer && ab);
  COV_STALL: cover property (completion_valid && !completion_ready);
  COV_MULTI: cover property (xfer && completion_last_beat && mid);
endmodule : ccsb_assertions

// ### testbench/tb_top.sv
// Purpose: Self-checking bench joining the user source and the core sink.
// Assumes: Inputs driven 5 ns after the rising edge.
// Notes: Table rows first, then parity error and reset recovery.
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import ccsb_pkg::*;
  typedef struct packed {
    logic [7:0] b;
    logic ab, eo, np, ep, st, sp, kp;
    logic [1:0] w;
    logic nu, ds;
  } ccsb_row_s;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic st = 1'b0, np = 1'b0, ab = 1'b0, eo = 1'b0, sp = 1'b0, kp = 1'b0, ep = 1'b0;
  logic ordy = 1'b1;
  logic [7:0] bt = 8'h01;
  logic [1:0] w = CCSB_WIDTH_256;
  logic [CCSB_DATA_W-1:0] seed = '0;
  logic [CCSB_DATA_W-1:0] o_data, first;
  logic dv, dl, nul, dis, aer, ierr, busy;
  int fail_count = 0, compares = 0, cyc = 0, ndv, ndl, nnu, nds, naer;
  ccsb_row_s rows [9] = '{
    '{8'h01, 0, 0, 0, 0, 0, 1, 1, CCSB_WIDTH_256, 0, 0},
    '{8'h04, 0, 0, 0, 1, 1, 1, 1, CCSB_WIDTH_256, 0, 0},
    '{8'h04, 1, 0, 0, 1, 0, 1, 1, CCSB_WIDTH_256, 1, 0},
    '{8'h04, 1, 1, 0, 0, 1, 1, 1, CCSB_WIDTH_256, 1, 0},
    '{8'h01, 1, 0, 0, 1, 0, 1, 1, CCSB_WIDTH_256, 0, 0},
    '{8'h04, 1, 0, 1, 1, 0, 1, 1, CCSB_WIDTH_256, 0, 0},
    '{8'h02, 0, 0, 0, 0, 0, 1, 1, CCSB_WIDTH_64, 0, 0},
    '{8'h02, 0, 0, 0, 0, 1, 1, 1, CCSB_WIDTH_128, 0, 0},
    '{8'h02, 0, 0, 0, 0, 0, 0, 0, CCSB_WIDTH_256, 0, 0}};
  ccsb_if link ();
  ccsb_user_source ccsb_user_source_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .link(link),
    .i_start(st), .i_beats(bt), .i_seed(seed), .i_non_posted(np), .i_abort_req(ab),
    .i_end_on_abort(eo), .i_parity_en(sp), .i_width(w), .o_busy(busy));
  ccsb_core_sink ccsb_core_sink_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .link(link),
    .i_width(w), .i_parity_en(kp), .i_is_endpoint(ep), .i_out_ready(ordy), .o_data(o_data),
    .o_data_valid(dv), .o_data_last(dl), .o_nullify(nul), .o_discard(dis),
    .o_aer_report(aer), .o_internal_err(ierr));
  ccsb_assertions ccsb_assertions_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .completion_data_bus(link.completion_data_bus),
    .completion_sideband_bus(link.completion_sideband_bus),
    .completion_valid(link.completion_valid), .completion_ready(link.completion_ready),
    .completion_last_beat(link.completion_last_beat));
  // Clock at 50 ns period.
  always #25 i_ref_clk = ~i_ref_clk;
  // Counts sink pulses where they are settled.
  always @(negedge i_ref_clk) begin
    if (dv && ndv == 0) begin
      first = o_data;
    end
    ndv += int'(dv);
    ndl += int'(dl);
    nnu += int'(nul);
    nds += int'(dis);
    naer += int'(aer);
  end
  // Cuts a hang short.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  // Sends one packet and waits for it to settle, stalling the sink if asked.
  task automatic send(input logic stall);
    ndv = 0;
    ndl = 0;
    nnu = 0;
    nds = 0;
    naer = 0;
    @(posedge i_ref_clk);
    #5 st = 1'b1;
    @(posedge i_ref_clk);
    #5 st = 1'b0;
    for (int i = 0; i < 100 && busy === 1'b1; i++) begin
      @(posedge i_ref_clk);
      #5 ordy = !stall || i[0];
    end
    repeat (3) @(posedge i_ref_clk);
    #5 ordy = 1'b1;
  endtask : send
  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Table rows, then parity error with reset recovery.
  initial begin
    repeat (10) @(posedge i_ref_clk);
    #5 i_rstn = 1'b1;
    foreach (rows[k]) begin
      {bt, ab, eo, np, ep} = {rows[k].b, rows[k].ab, rows[k].eo, rows[k].np, rows[k].ep};
      {sp, kp, w} = {rows[k].sp, rows[k].kp, rows[k].w};
      seed = {8{24'h0, k[7:0] + 8'h10}};
      send(rows[k].st);
      `CHK("nullify", int'(rows[k].nu), nnu)
      `CHK("aer", int'(rows[k].nu & rows[k].ep), naer)
      `CHK("discard", int'(rows[k].ds), nds)
      `CHK("last", 1, ndl)
      `CHK("data", seed, first)
      if (!rows[k].eo) begin
        `CHK("beats", int'(rows[k].b), ndv)
      end else begin
        `CHK("beats", 3, ndv)
      end
    end
    // Abort raised on the third beat, dropped before the fourth: still nullified.
    {bt, ab, eo, np, ep} = {8'h04, 1'b1, 1'b0, 1'b0, 1'b0};
    {sp, kp} = 2'h3;
    fork
      send(1'b0);
      begin
        repeat (4) @(posedge i_ref_clk);
        #5 ab = 1'b0;
      end
    join
    `CHK("sticky", 1, nnu)
    `CHK("sticky beats", 4, ndv)
    // All-zero bytes need set parity bits, so the zero parity field is wrong.
    {bt, ab, sp, kp, ep} = {8'h02, 1'b0, 1'b0, 1'b1, 1'b1};
    seed = '0;
    send(1'b0);
    `CHK("discard", 1, nds)
    `CHK("interr", 1'b1, ierr)
    i_rstn = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #5 i_rstn = 1'b1;
    @(posedge i_ref_clk);
    #5 `CHK("interr", 1'b0, ierr)
    end_of_test();
  end
endmodule : tb_top
